/* jk_flop_pkg.sv */
// shared types and constants for the jk storage element
package jk_flop_pkg;

  // ****************************************
  // carrier for the two data inputs
  // ****************************************
  typedef struct packed
  {
    logic j;  // one-load input
    logic k;  // zero-load input
  } jk_inputs_t;

  // ****************************************
  // forced output levels and reset values
  // ****************************************
  localparam logic CLEAR_TRUE      = 1'h0;
  localparam logic CLEAR_INVERTED  = 1'h1;
  localparam logic PRESET_TRUE     = 1'h1;
  localparam logic PRESET_INVERTED = 1'h0;
  localparam logic BOTH_LOW_LEVEL  = 1'h0;
  localparam logic SYNC_RESET_INIT = 1'h0;
  localparam logic SYNC_RESET_DONE = 1'h1;

  // ****************************************
  // modes of the next-state selection
  // ****************************************
  typedef enum logic [1:0]
  {
    MODE_JK   = 2'h1,
    MODE_SCAN = 2'h2
  } load_mode_t;

endpackage

/* reset_release.sv */
// two-stage release of the active-low system reset
`timescale 1ns/1ps

module reset_release
(
  // clock and raw reset
  input  wire logic clock,
  input  wire logic resetn,
  // released copy
  output logic      rst_sync_n
);
  import jk_flop_pkg::*;

  logic first_stage;
  logic next_first;
  logic next_sync;

  always_comb
  begin
    next_first = SYNC_RESET_DONE;
    next_sync  = first_stage;
  end

  // assertion is immediate, release waits two edges
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      first_stage <= SYNC_RESET_INIT;
      rst_sync_n  <= SYNC_RESET_INIT;
    end
    else
    begin
      first_stage <= next_first;
      rst_sync_n  <= next_sync;
    end
  end

endmodule // reset_release

/* jk_flop_set_reset_scan.sv */
// jk flip-flop with asynchronous clear and preset and an optional scan path
//
// How it works
// - With controls high an edge clears on k, sets on j, holds on neither, toggles on both.
// - State changes only on a rising edge, unless an asynchronous control or the system reset is low.
// - Clear low gives 0/1, preset low gives 1/0, both low give 0/0, at once and clockless.
// - With scan fitted and selected, an edge loads scan in and its complement, not j and k.
// - Clear and preset override scan and jk mode alike, with the same forced levels.
`timescale 1ns/1ps

module jk_flop_set_reset_scan
#(
  parameter bit HAS_SCAN = 1'b1
)
(
  // clock and system reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // asynchronous controls
  input  wire logic                   async_clear_n,
  input  wire logic                   async_preset_n,
  // data inputs
  input  wire jk_flop_pkg::jk_inputs_t data_in,
  // scan path
  input  wire logic                   scan_select,
  input  wire logic                   scan_serial_in,
  // outputs
  output logic                        true_output,
  output logic                        inverted_output
);
  import jk_flop_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  if (HAS_SCAN !== 1'b0 && HAS_SCAN !== 1'b1)
  begin : bad_scan_param
    $error("HAS_SCAN must be 0 or 1");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic rst_sync_n;

  reset_release reset_release_inst
  (
    .clock      (clock),
    .resetn     (resetn),
    .rst_sync_n (rst_sync_n)
  );

  // ****************************************
  // next-state selection
  // ****************************************
  function automatic logic jk_next(input jk_inputs_t in, input logic state);
    unique case ({in.j, in.k})
      2'h0:    jk_next = state;
      2'h1:    jk_next = 1'h0;
      2'h2:    jk_next = 1'h1;
      default: jk_next = ~state;
    endcase
  endfunction

  load_mode_t mode;
  logic       next_true;
  logic       next_inverted;

  always_comb
  begin
    // scan select is ignored when the scan path is not fitted
    mode = (HAS_SCAN && scan_select) ? MODE_SCAN : MODE_JK;
    unique case (mode)
      MODE_SCAN:
      begin
        next_true     = scan_serial_in;
        next_inverted = ~scan_serial_in;
      end
      MODE_JK:
      begin
        next_true     = jk_next(data_in, true_output);
        next_inverted = ~jk_next(data_in, true_output);
      end
    endcase
  end

  // ****************************************
  // storage
  // ****************************************
  // two separate flops so that both-low can drive both outputs to 0;
  // each flop has one constant for each asynchronous control
  // releasing one control while the other stays low must hand over at once, but a
  // rising control is no flop event, so each flop also watches a level that falls
  // when its own forcing control becomes the only one asserted
  // limitation: a release of both in one instant keeps 0/0 only if both settle together
  logic preset_only_n;
  logic clear_only_n;

  assign preset_only_n = async_preset_n || !async_clear_n;
  assign clear_only_n  = async_clear_n || !async_preset_n;

  // clear wins on the true flop
  always_ff @(posedge clock or negedge rst_sync_n or negedge async_clear_n
              or negedge preset_only_n)
  begin
    if (!rst_sync_n)
      true_output <= CLEAR_TRUE;
    else if (!async_clear_n)
      true_output <= CLEAR_TRUE;
    else if (!preset_only_n)
      true_output <= PRESET_TRUE;
    else
      true_output <= next_true;
  end

  // preset wins on the inverted flop
  always_ff @(posedge clock or negedge rst_sync_n or negedge async_preset_n
              or negedge clear_only_n)
  begin
    if (!rst_sync_n)
      inverted_output <= CLEAR_INVERTED;
    else if (!async_preset_n)
      inverted_output <= PRESET_INVERTED;
    else if (!clear_only_n)
      inverted_output <= CLEAR_INVERTED;
    else
      inverted_output <= next_inverted;
  end

  // ****************************************
  // assertions
  // ****************************************
  logic controls_free;
  logic jk_mode;

  assign controls_free = async_clear_n && async_preset_n;
  assign jk_mode       = !(HAS_SCAN && scan_select);

  chk_jk_clear: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && jk_mode && !data_in.j && data_in.k)
    |=> (!controls_free || (!true_output && inverted_output)))
    else $error("k alone did not clear the element");

  chk_jk_set: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && jk_mode && data_in.j && !data_in.k)
    |=> (!controls_free || (true_output && !inverted_output)))
    else $error("j alone did not set the element");

  chk_jk_toggle: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && jk_mode && data_in.j && data_in.k)
    |=> (!controls_free || (true_output == !$past(true_output))))
    else $error("j and k high did not invert the state");

  chk_jk_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && jk_mode && !data_in.j && !data_in.k)
    |=> (!controls_free || $stable(true_output)))
    else $error("state changed with j and k low");

  // outputs stay complementary once the controls have been free for two edges
  chk_out_complement: assert property (@(posedge clock) disable iff (!rst_sync_n)
    controls_free ##1 controls_free |-> (inverted_output == !true_output))
    else $error("outputs not complementary in normal operation");

  // clear alone forces 0 and 1
  chk_async_clear: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_clear_n && async_preset_n)
    |-> (true_output == CLEAR_TRUE && inverted_output == CLEAR_INVERTED))
    else $error("clear did not force the outputs");

  // preset alone forces 1 and 0
  chk_async_preset: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (async_clear_n && !async_preset_n)
    |-> (true_output == PRESET_TRUE && inverted_output == PRESET_INVERTED))
    else $error("preset did not force the outputs");

  // both low drive both outputs low
  chk_async_both: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_clear_n && !async_preset_n)
    |-> (true_output == BOTH_LOW_LEVEL && inverted_output == BOTH_LOW_LEVEL))
    else $error("both controls low did not drive both outputs low");

  // scan load ignores j and k
  chk_scan_load: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && HAS_SCAN && scan_select)
    |=> (!controls_free || (true_output == $past(scan_serial_in)
         && inverted_output == !$past(scan_serial_in))))
    else $error("scan load did not capture the scan input");

  // clear overrides scan mode held over several edges
  chk_scan_clear: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_clear_n && async_preset_n && scan_select)[*3]
    |-> (!true_output && inverted_output))
    else $error("clear did not hold over scan mode");

  // release from both low keeps 0 and 0 until the next edge
  chk_both_release: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && $past(!async_clear_n && !async_preset_n))
    |-> (true_output == BOTH_LOW_LEVEL && inverted_output == BOTH_LOW_LEVEL))
    else $error("release from both low did not hold both outputs low");

  // ****************************************
  // coverage
  // ****************************************
  cov_toggle: cover property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && jk_mode && data_in.j && data_in.k) ##1 controls_free);

  cov_scan: cover property (@(posedge clock) disable iff (!rst_sync_n)
    (controls_free && HAS_SCAN && scan_select && scan_serial_in) ##1 controls_free);

  cov_both_low: cover property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_clear_n && !async_preset_n));

  cov_preset_then_clear: cover property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_preset_n && async_clear_n) ##1 controls_free ##1 (!async_clear_n));

  cov_clear_release: cover property (@(posedge clock) disable iff (!rst_sync_n)
    (!async_clear_n && !async_preset_n) ##1 (async_clear_n && !async_preset_n));

endmodule // jk_flop_set_reset_scan

/* async_ctrl_model.sv */
// surrounding-logic model that drives the asynchronous controls
`timescale 1ns/1ps

module async_ctrl_model
(
  // clock and requests from the bench
  input  wire logic clock,
  input  wire logic req_clear,
  input  wire logic req_preset,
  // controls toward the element
  output logic      async_clear_n,
  output logic      async_preset_n
);
  // falling-edge release
  // half a cycle away from every rising edge, so the first capture is never ambiguous
  always @(negedge clock)
  begin
    async_clear_n  <= ~req_clear;
    async_preset_n <= ~req_preset;
  end
endmodule // async_ctrl_model

/* jk_flop_set_reset_scan_bench.sv */
// self-checking bench for the jk storage element
`timescale 1ns/1ps

module jk_flop_set_reset_scan_bench;
  import jk_flop_pkg::*;

  logic       clock;
  logic       resetn;
  jk_inputs_t data_in;
  logic       scan_select;
  logic       scan_serial_in;
  logic       req_clear;
  logic       req_preset;
  logic       async_clear_n;
  logic       async_preset_n;
  logic       true_output;
  logic       inverted_output;
  logic [1:0] outs;
  logic       exp_q;
  logic       exp_qn;
  logic [5:0] stim;
  logic [31:0] rnd;
  int         err_total;
  int         samples_checked;
  int         seed;
  // corner cases: {clear, preset, scan select, scan in, j, k}
  logic [5:0] corner [10] = '{6'h03, 6'h03, 6'h0d, 6'h0a, 6'h06, 6'h30, 6'h03, 6'h23, 6'h12,
                              6'h01};

  async_ctrl_model partner (.clock(clock), .req_clear(req_clear), .req_preset(req_preset),
    .async_clear_n(async_clear_n), .async_preset_n(async_preset_n));

  jk_flop_set_reset_scan #(.HAS_SCAN(1'b1)) uut (.clock(clock), .resetn(resetn),
    .async_clear_n(async_clear_n), .async_preset_n(async_preset_n), .data_in(data_in),
    .scan_select(scan_select), .scan_serial_in(scan_serial_in),
    .true_output(true_output), .inverted_output(inverted_output));

  assign outs = {true_output, inverted_output};

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic next_state(input logic q, input jk_inputs_t d,
                                      input logic se, input logic si);
    if (se)
      return si;
    case ({d.j, d.k})
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      2'h3: return ~q;
      default: return q;
    endcase
  endfunction

  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // stimulus and checks
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    seed = 80436;
    err_total = 0;
    samples_checked = 0;
    resetn = 1'b0;
    data_in = '0;
    scan_select = 1'b0;
    scan_serial_in = 1'b0;
    req_clear = 1'b0;
    req_preset = 1'b0;
    exp_q = CLEAR_TRUE;
    exp_qn = CLEAR_INVERTED;
    repeat (8) @(posedge clock);
    #1 check("reset level", outs, {exp_q, exp_qn});
    @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clock);
      if (async_clear_n && async_preset_n)
      begin
        exp_q = next_state(exp_q, data_in, scan_select, scan_serial_in);
        exp_qn = ~exp_q;
      end
      rnd = $random(seed);
      stim = (i < 10) ? corner[i] : rnd[5:0];
      if (i >= 10 && rnd[8:7] != 2'h0)
        stim[5:4] = 2'h0;
      req_clear <= stim[5];
      req_preset <= stim[4];
      scan_select <= stim[3];
      scan_serial_in <= stim[2];
      data_in <= jk_inputs_t'(stim[1:0]);
      #1 check("edge load", outs, {exp_q, exp_qn});
      @(negedge clock);
      #1;
      if (req_clear && req_preset)
        {exp_q, exp_qn} = {BOTH_LOW_LEVEL, BOTH_LOW_LEVEL};
      else if (req_clear)
        {exp_q, exp_qn} = {CLEAR_TRUE, CLEAR_INVERTED};
      else if (req_preset)
        {exp_q, exp_qn} = {PRESET_TRUE, PRESET_INVERTED};
      check("between edges", outs, {exp_q, exp_qn});
    end
    end_of_test();
  end
endmodule // jk_flop_set_reset_scan_bench
